/* verilog/dfp_supervisor.sv */
/*
  Fault and protection supervisor of a motor drive: inverse-time overload with
  pre-warning, overvoltage and overcurrent stall hold, power-on ground-short
  check, fault auto-reset with retry budget, fault history, APB registers and
  a masked interrupt.
  Assumes current and bus voltage samples synchronous to mclk_in, current in
  the same unit as the rated current setting, bus voltage in volts.
*/
`default_nettype none
`include "dfp_regs.svh"

module dfp_supervisor
  import dfp_pkg::*;
#(
  parameter int MS_CYCLES = `DFP_MS_NS / `DFP_CLK_PERIOD_NS
) (
  input  wire logic        mclk_in,
  input  wire logic        reset_in,
  input  wire logic        ce_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [3:0]  pstrb_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic [15:0] current_in,
  input  wire logic [15:0] bus_voltage_in,
  input  wire logic        accel_in,
  input  wire logic        decel_in,
  input  wire logic        ground_fault_in,
  input  wire logic        ext_fault_in,
  input  wire logic [6:0]  ext_fault_code_in,
  output logic             freq_hold_out,
  output logic             overload_warn_out,
  output logic             fault_out,
  output logic             trip_out,
  output logic             motor_output_phases_out,
  output logic             irq_out
);

  // --------------------------------------------------------------------------
  // Constants
  // --------------------------------------------------------------------------
  localparam int GS_CYCLES_MS = `DFP_GS_TIME_MS;
  localparam logic [21:0] OL_LIMIT = 22'(`DFP_OL_LIMIT_S * `DFP_MS_PER_S);
  localparam logic [7:0][7:0] OL_LEVEL = `DFP_OL_LEVELS;
  localparam logic [7:0][7:0] OL_RATE = `DFP_OL_RATES;
  localparam logic [6:0] CODE_OVERLOAD = 7'h0b;  // Arbitrary code value
  localparam logic [6:0] CODE_GROUND = 7'h17;  // Arbitrary code value

  dfp_state_t s;
  dfp_state_t next_s;

  logic [7:0]  lvl_hit;
  logic [39:0] cur_scaled;
  logic [25:0] rated_gain;

  function automatic logic [15:0] clamp(input logic [15:0] v,
                                        input logic [15:0] lo,
                                        input logic [15:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // --------------------------------------------------------------------------
  // Overload curve level compare
  // --------------------------------------------------------------------------
  assign cur_scaled = 40'(current_in) * 40'(`DFP_GAIN_SCALE);
  assign rated_gain = 26'(s.rated_cur) * 26'(s.ol_gain);

  generate
    for (genvar i = 0; i < 8; i++) begin : g_level
      assign lvl_hit[i] = cur_scaled >= 40'(rated_gain) * 40'(OL_LEVEL[i]);
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    logic        setup;
    logic        wr;
    logic        ms_tick;
    logic        tenth_tick;
    logic [7:0]  rate;
    logic [22:0] heat_sum;
    logic [9:0]  base_v;
    logic [31:0] v_meas;
    logic [31:0] v_trip;
    logic [31:0] v_rel;
    logic [31:0] i_meas;
    logic [31:0] i_trip;
    logic [31:0] i_rel;
    logic        new_fault;
    logic [6:0]  new_code;
    logic        man_rst;
    logic        auto_rst;
    logic        warn_rise;
    logic        ov_rise;
    logic        oc_rise;
    logic [4:0]  ev;
    logic [31:0] rd;
    logic        hit;
    setup = 1'b0;
    wr = 1'b0;
    ms_tick = 1'b0;
    tenth_tick = 1'b0;
    rate = 8'h00;
    heat_sum = 23'h000000;
    base_v = `DFP_BASE_V_220;
    v_meas = 32'h0;
    v_trip = 32'h0;
    v_rel = 32'h0;
    i_meas = 32'h0;
    i_trip = 32'h0;
    i_rel = 32'h0;
    new_fault = 1'b0;
    new_code = 7'h00;
    man_rst = 1'b0;
    auto_rst = 1'b0;
    warn_rise = 1'b0;
    ov_rise = 1'b0;
    oc_rise = 1'b0;
    ev = 5'h00;
    rd = 32'h0;
    hit = 1'b1;
    next_s = s;

    // Time base: millisecond and tenth-second ticks
    ms_tick = s.ms_cnt == 17'(MS_CYCLES - 1);
    next_s.ms_cnt = ms_tick ? 17'h0 : s.ms_cnt + 17'h1;
    if (ms_tick) begin
      tenth_tick = s.tenth_cnt == 7'(`DFP_TENTHS_MS - 1);
      next_s.tenth_cnt = tenth_tick ? 7'h0 : s.tenth_cnt + 7'h1;
    end

    // APB register access, registered read data at setup
    setup = psel_in && !penable_in;
    wr = psel_in && penable_in && pwrite_in;
    if (setup) begin
      case (paddr_in)
        `DFP_OFF_CTRL: begin
          rd[`DFP_CTRL_OL_SEL] = s.ol_sel;
          rd[`DFP_CTRL_GS_EN] = s.gs_en;
          rd[`DFP_CTRL_AR_ACT] = s.ar_act;
        end
        `DFP_OFF_OL_CFG: rd = {9'h0, s.warn_coef, 6'h0, s.ol_gain};
        `DFP_OFF_STALL_CFG: rd = {s.oc_thr, 1'b0, s.oc_gain, s.ov_thr, 1'b0, s.ov_gain};
        `DFP_OFF_AR_CFG: rd = {6'h0, s.ar_intv, 11'h0, s.ar_count};
        `DFP_OFF_MOTOR: rd = {13'h0, s.volt_class, s.rated_cur};
        `DFP_OFF_STATUS: begin
          rd = {11'h0, s.retries, 1'b0, s.fault_code, 1'b0, s.oc_hold, s.ov_hold,
                s.warn, s.gs == DFP_GS_RUN, s.fault_term, s.flt};
        end
        `DFP_OFF_HISTORY: rd = {9'h0, s.hist[2], 1'b0, s.hist[1], 1'b0, s.hist[0]};
        `DFP_OFF_INT_STAT: rd = {27'h0, s.int_stat};
        `DFP_OFF_INT_MASK: rd = {27'h0, s.int_mask};
        default: hit = 1'b0;
      endcase
      next_s.prdata = pwrite_in ? 32'h0 : rd;
      next_s.pslverr = !hit;
    end

    if (wr && !s.pslverr && pstrb_in != 4'h0) begin
      case (paddr_in)
        `DFP_OFF_CTRL: begin
          next_s.ol_sel = pwdata_in[`DFP_CTRL_OL_SEL];
          next_s.gs_en = pwdata_in[`DFP_CTRL_GS_EN];
          next_s.ar_act = pwdata_in[`DFP_CTRL_AR_ACT];
          man_rst = pwdata_in[`DFP_CTRL_MAN_RST];
        end
        `DFP_OFF_OL_CFG: begin
          next_s.ol_gain = 10'(clamp({6'h0, pwdata_in[9:0]},
                                     `DFP_MIN_OL_GAIN, `DFP_MAX_OL_GAIN));
          next_s.warn_coef = 7'(clamp({9'h0, pwdata_in[`DFP_OL_WARN_LSB +: 7]},
                                      `DFP_MIN_WARN, `DFP_MAX_WARN));
        end
        `DFP_OFF_STALL_CFG: begin
          next_s.ov_gain = 7'(clamp({9'h0, pwdata_in[6:0]},
                                    `DFP_RST_OV_GAIN, `DFP_MAX_GAIN));
          next_s.ov_thr = 8'(clamp({8'h0, pwdata_in[`DFP_ST_OVT_LSB +: 8]},
                                   `DFP_MIN_OV_THR, `DFP_MAX_OV_THR));
          next_s.oc_gain = 7'(clamp({9'h0, pwdata_in[`DFP_ST_OCG_LSB +: 7]},
                                    `DFP_RST_OV_GAIN, `DFP_MAX_GAIN));
          next_s.oc_thr = 8'(clamp({8'h0, pwdata_in[`DFP_ST_OCT_LSB +: 8]},
                                   `DFP_MIN_OC_THR, `DFP_MAX_OC_THR));
        end
        `DFP_OFF_AR_CFG: begin
          next_s.ar_count = 5'(clamp({11'h0, pwdata_in[4:0]},
                                     `DFP_RST_AR_COUNT, `DFP_MAX_AR_COUNT));
          next_s.ar_intv = 10'(clamp({6'h0, pwdata_in[`DFP_AR_INTV_LSB +: 10]},
                                     `DFP_MIN_AR_INTV, `DFP_MAX_AR_INTV));
        end
        `DFP_OFF_MOTOR: begin
          next_s.rated_cur = pwdata_in[15:0];
          next_s.volt_class = 3'(clamp({13'h0, pwdata_in[`DFP_MOT_CLASS_LSB +: 3]},
                                       16'h0000, `DFP_MAX_CLASS));
        end
        `DFP_OFF_INT_MASK: next_s.int_mask = pwdata_in[4:0];
        default: ;
      endcase
    end

    // Inverse-time overload heat, highest level hit sets the rate
    for (int i = 0; i < 8; i++) begin
      if (lvl_hit[i]) begin
        rate = OL_RATE[i];
      end
    end
    if (!s.ol_sel) begin
      next_s.heat = 22'h0;
    end else if (ms_tick) begin
      if (rate != 8'h00) begin
        heat_sum = 23'(s.heat) + 23'(rate);
        next_s.heat = heat_sum > 23'(OL_LIMIT) ? OL_LIMIT : heat_sum[21:0];
      end else if (s.heat != 22'h0) begin
        next_s.heat = s.heat - 22'h1;
      end
    end
    next_s.warn = s.ol_sel && (32'(s.heat) * 32'(`DFP_PCT_SCALE) >
                               32'(OL_LIMIT) * 32'(s.warn_coef));

    // Overvoltage stall during deceleration
    case (s.volt_class)
      3'h0, 3'h1: base_v = `DFP_BASE_V_220;
      3'h2: base_v = `DFP_BASE_V_380;
      3'h3: base_v = `DFP_BASE_V_480;
      3'h4: base_v = `DFP_BASE_V_690;
      default: base_v = `DFP_BASE_V_220;
    endcase
    v_meas = 32'(bus_voltage_in) * 32'(`DFP_PCT_SCALE);
    v_trip = 32'(base_v) * 32'(s.ov_thr);
    // Larger gain widens hysteresis, holding longer
    v_rel = 32'(base_v) * 32'(s.ov_thr - 8'(s.ov_gain >> 2));
    if (s.ov_gain == 7'h0 || !decel_in) begin
      next_s.ov_hold = 1'b0;
    end else if (v_meas > v_trip) begin
      next_s.ov_hold = 1'b1;
    end else if (v_meas <= v_rel) begin
      next_s.ov_hold = 1'b0;
    end

    // Overcurrent stall during either ramp
    i_meas = 32'(current_in) * 32'(`DFP_PCT_SCALE);
    i_trip = 32'(s.rated_cur) * 32'(s.oc_thr);
    i_rel = 32'(s.rated_cur) * 32'(s.oc_thr - 8'(s.oc_gain >> 2));
    if (s.oc_gain == 7'h0 || !(accel_in || decel_in)) begin
      next_s.oc_hold = 1'b0;
    end else if (i_meas > i_trip) begin
      next_s.oc_hold = 1'b1;
    end else if (i_meas <= i_rel) begin
      next_s.oc_hold = 1'b0;
    end

    // Power-on ground-short check
    case (s.gs)
      DFP_GS_IDLE: begin
        next_s.gs = s.gs_en ? DFP_GS_RUN : DFP_GS_DONE;
        next_s.gs_cnt = 16'h0;
      end
      DFP_GS_RUN: begin
        if (ground_fault_in) begin
          next_s.gs = DFP_GS_DONE;
          new_fault = 1'b1;
          new_code = CODE_GROUND;
        end else if (ms_tick) begin
          next_s.gs_cnt = s.gs_cnt + 16'h1;
          if (s.gs_cnt == 16'(GS_CYCLES_MS - 1)) begin
            next_s.gs = DFP_GS_DONE;
          end
        end
      end
      DFP_GS_DONE: next_s.gs = DFP_GS_DONE;
      default: next_s.gs = DFP_GS_DONE;
    endcase

    // Fault sources, priority ground, overload, external
    if (!new_fault) begin
      if (s.ol_sel && s.heat >= OL_LIMIT) begin
        new_fault = 1'b1;
        new_code = CODE_OVERLOAD;
      end else if (ext_fault_in) begin
        new_fault = 1'b1;
        new_code = ext_fault_code_in;
      end
    end

    // Fault state and auto-reset sequencing
    case (s.flt)
      DFP_FLT_OK: begin
        if (new_fault && !man_rst) begin
          next_s.fault_code = new_code;
          next_s.hist = {s.hist[1:0], new_code};
          next_s.intv_cnt = 10'h0;
          // Restart time base so the full interval elapses
          next_s.ms_cnt = 17'h0;
          next_s.tenth_cnt = 7'h0;
          next_s.flt = (s.retries < s.ar_count) ? DFP_FLT_WAIT : DFP_FLT_LOCK;
        end
      end
      DFP_FLT_WAIT: begin
        if (tenth_tick) begin
          next_s.intv_cnt = s.intv_cnt + 10'h1;
          if (s.intv_cnt + 10'h1 >= s.ar_intv) begin
            auto_rst = 1'b1;
            next_s.flt = DFP_FLT_OK;
            next_s.retries = s.retries + 5'h1;
            next_s.fault_code = 7'h0;
          end
        end
      end
      DFP_FLT_LOCK: next_s.flt = DFP_FLT_LOCK;
      default: next_s.flt = DFP_FLT_LOCK;
    endcase
    if (man_rst) begin
      next_s.flt = DFP_FLT_OK;
      next_s.fault_code = 7'h0;
      next_s.retries = 5'h0;
    end
    next_s.fault_term = (next_s.flt == DFP_FLT_LOCK) ||
                        (next_s.flt == DFP_FLT_WAIT && s.ar_act);

    // Sticky interrupt status, set wins over clear
    warn_rise = next_s.warn && !s.warn;
    ov_rise = next_s.ov_hold && !s.ov_hold;
    oc_rise = next_s.oc_hold && !s.oc_hold;
    ev[`DFP_INT_FAULT] = s.flt == DFP_FLT_OK && next_s.flt != DFP_FLT_OK;
    ev[`DFP_INT_WARN] = warn_rise;
    ev[`DFP_INT_OV_STALL] = ov_rise;
    ev[`DFP_INT_OC_STALL] = oc_rise;
    ev[`DFP_INT_AUTO_RST] = auto_rst;
    if (wr && paddr_in == `DFP_OFF_INT_STAT && pstrb_in[0]) begin
      next_s.int_stat = s.int_stat & ~pwdata_in[4:0];
    end
    next_s.int_stat = next_s.int_stat | ev;
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      s <= '0;
      s.ol_sel <= `DFP_RST_OL_SEL;
      s.gs_en <= `DFP_RST_GS_EN;
      s.ar_act <= `DFP_RST_AR_ACT;
      s.ol_gain <= 10'(`DFP_RST_OL_GAIN);
      s.warn_coef <= 7'(`DFP_RST_WARN);
      s.ov_gain <= 7'(`DFP_RST_OV_GAIN);
      s.ov_thr <= 8'(`DFP_RST_OV_THR);
      s.oc_gain <= 7'(`DFP_RST_OC_GAIN);
      s.oc_thr <= 8'(`DFP_RST_OC_THR);
      s.ar_count <= 5'(`DFP_RST_AR_COUNT);
      s.ar_intv <= 10'(`DFP_RST_AR_INTV);
      s.rated_cur <= `DFP_RST_RATED;
      s.gs <= DFP_GS_IDLE;
      s.flt <= DFP_FLT_OK;
    end else if (ce_in) begin
      s <= next_s;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign prdata_out = s.prdata;
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && s.pslverr;
  assign freq_hold_out = s.ov_hold || s.oc_hold;
  assign overload_warn_out = s.warn;
  assign fault_out = s.fault_term;
  assign trip_out = s.flt != DFP_FLT_OK;
  assign motor_output_phases_out = s.gs == DFP_GS_RUN;
  assign irq_out = |(s.int_stat & s.int_mask);

endmodule
`default_nettype wire

/* verilog/dfp_regs.svh */
/*
  Register offsets, field positions, reset values and timing figures of the
  drive fault and protection supervisor.
  Assumes inclusion by bare name from design files that also import dfp_pkg.
*/
`ifndef DFP_REGS_SVH
`define DFP_REGS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define DFP_OFF_CTRL      12'h000
`define DFP_OFF_OL_CFG    12'h004
`define DFP_OFF_STALL_CFG 12'h008
`define DFP_OFF_AR_CFG    12'h00c
`define DFP_OFF_MOTOR     12'h010
`define DFP_OFF_STATUS    12'h014
`define DFP_OFF_HISTORY   12'h018
`define DFP_OFF_INT_STAT  12'h01c
`define DFP_OFF_INT_MASK  12'h020

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define DFP_CTRL_OL_SEL   0
`define DFP_CTRL_GS_EN    1
`define DFP_CTRL_AR_ACT   2
`define DFP_CTRL_MAN_RST  3
`define DFP_OL_WARN_LSB   16
`define DFP_ST_OVT_LSB    8
`define DFP_ST_OCG_LSB    16
`define DFP_ST_OCT_LSB    24
`define DFP_AR_INTV_LSB   16
`define DFP_MOT_CLASS_LSB 16
`define DFP_STS_CODE_LSB  8
`define DFP_STS_RETRY_LSB 16
`define DFP_HIST_1_LSB    8
`define DFP_HIST_2_LSB    16
`define DFP_INT_FAULT     0
`define DFP_INT_WARN      1
`define DFP_INT_OV_STALL  2
`define DFP_INT_OC_STALL  3
`define DFP_INT_AUTO_RST  4

// ----------------------------------------------------------------------------
// Reset values and setting ranges
// ----------------------------------------------------------------------------
`define DFP_RST_OL_SEL    1'b1
`define DFP_RST_GS_EN     1'b1
`define DFP_RST_AR_ACT    1'b0
`define DFP_RST_OL_GAIN   16'h0064
`define DFP_MIN_OL_GAIN   16'h0014
`define DFP_MAX_OL_GAIN   16'h03e8
`define DFP_RST_WARN      16'h0050
`define DFP_MIN_WARN      16'h0032
`define DFP_MAX_WARN      16'h0064
`define DFP_RST_OV_GAIN   16'h0000
`define DFP_MAX_GAIN      16'h0064
`define DFP_RST_OV_THR    16'h0082
`define DFP_MIN_OV_THR    16'h0078
`define DFP_MAX_OV_THR    16'h0096
`define DFP_RST_OC_GAIN   16'h0014
`define DFP_RST_OC_THR    16'h0096
`define DFP_MIN_OC_THR    16'h0064
`define DFP_MAX_OC_THR    16'h00c8
`define DFP_RST_AR_COUNT  16'h0000
`define DFP_MAX_AR_COUNT  16'h0014
`define DFP_RST_AR_INTV   16'h000a
`define DFP_MIN_AR_INTV   16'h0001
`define DFP_MAX_AR_INTV   16'h03e8
`define DFP_RST_RATED     16'h0064
`define DFP_MAX_CLASS     16'h0004

// ----------------------------------------------------------------------------
// Overload curve, bus voltage bases, timing
// ----------------------------------------------------------------------------
`define DFP_OL_LEVELS     {8'hdc, 8'hd2, 8'hc8, 8'hbe, 8'hb4, 8'haa, 8'ha0, 8'h96}
`define DFP_OL_RATES      {8'h3c, 8'h28, 8'h19, 8'h0f, 8'h08, 8'h04, 8'h02, 8'h01}
`define DFP_OL_LIMIT_S    3600
`define DFP_PCT_SCALE     100
`define DFP_GAIN_SCALE    10000
`define DFP_BASE_V_220    10'h122
`define DFP_BASE_V_380    10'h212
`define DFP_BASE_V_480    10'h26c
`define DFP_BASE_V_690    10'h370
`define DFP_CLK_PERIOD_NS 8
`define DFP_MS_NS         1000000
`define DFP_MS_PER_S      1000
`define DFP_TENTHS_MS     100
`define DFP_GS_TIME_MS    10

`endif

/* verilog/dfp_pkg.sv */
/*
  Types of the drive fault and protection supervisor.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package dfp_pkg;

  typedef enum logic [1:0] {
    DFP_GS_IDLE = 2'b00,
    DFP_GS_RUN  = 2'b01,
    DFP_GS_DONE = 2'b10
  } dfp_gs_t;

  typedef enum logic [1:0] {
    DFP_FLT_OK   = 2'b00,
    DFP_FLT_WAIT = 2'b01,
    DFP_FLT_LOCK = 2'b10
  } dfp_flt_t;

  typedef struct packed {
    logic            ol_sel;
    logic            gs_en;
    logic            ar_act;
    logic [9:0]      ol_gain;
    logic [6:0]      warn_coef;
    logic [6:0]      ov_gain;
    logic [7:0]      ov_thr;
    logic [6:0]      oc_gain;
    logic [7:0]      oc_thr;
    logic [4:0]      ar_count;
    logic [9:0]      ar_intv;
    logic [15:0]     rated_cur;
    logic [2:0]      volt_class;
    logic [4:0]      int_stat;
    logic [4:0]      int_mask;
    logic [31:0]     prdata;
    logic            pslverr;
    logic [16:0]     ms_cnt;
    logic [6:0]      tenth_cnt;
    logic [21:0]     heat;
    logic            warn;
    logic            ov_hold;
    logic            oc_hold;
    dfp_gs_t         gs;
    logic [15:0]     gs_cnt;
    dfp_flt_t        flt;
    logic            fault_term;
    logic [6:0]      fault_code;
    logic [4:0]      retries;
    logic [9:0]      intv_cnt;
    logic [2:0][6:0] hist;
  } dfp_state_t;

endpackage
`default_nettype wire

/* tb/dfp_sup_asserts.sv */
/*
  Port checker of the fault and protection supervisor.
  Assumes binding into dfp_supervisor with its MS_CYCLES handed on.
*/
`default_nettype none
module dfp_sup_asserts
  import dfp_pkg::*;
#(
  parameter int MS_CYCLES = 10
) (
  input wire logic        mclk_in,
  input wire logic        reset_in,
  input wire logic        ce_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        ext_fault_in,
  input wire logic        accel_in,
  input wire logic        decel_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        freq_hold_out,
  input wire logic        fault_out,
  input wire logic        trip_out,
  input wire logic        motor_output_phases_out
);
  // ----------------------------------------
  // Ground check drive length
  // ----------------------------------------
  logic [31:0] run_len;
  always_ff @(posedge mclk_in) begin
    if (reset_in || !motor_output_phases_out) begin
      run_len <= 32'h0;
    end else begin
      run_len <= run_len + 32'h1;
    end
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  pready_ok_a: assert property (pready_out) else $error("pready low");
  err_phase_a: assert property (pslverr_out |-> psel_in && penable_in) else $error("stray error");
  err_data_a: assert property (psel_in && penable_in && pslverr_out |-> prdata_out == 32'h0)
    else $error("error read not zero");
  hold_stop_a: assert property (ce_in && !accel_in && !decel_in |=> !freq_hold_out)
    else $error("hold outside ramp");
  hold_cause_a: assert property ($rose(freq_hold_out) |-> $past(accel_in) || $past(decel_in))
    else $error("hold without ramp");
  ext_trip_a: assert property (ce_in && ext_fault_in && !trip_out |=> trip_out)
    else $error("fault not taken");
  term_trip_a: assert property (fault_out |-> trip_out) else $error("terminal without fault");
  gs_start_a: assert property ($fell(reset_in) && ce_in |=> motor_output_phases_out)
    else $error("ground check not started");
  // A sensed ground short ends the drive early and trips
  gs_len_a: assert property ($fell(motor_output_phases_out) && !trip_out |->
    run_len >= 9 * MS_CYCLES && run_len <= 11 * MS_CYCLES) else $error("ground check length");
  cover property ($rose(trip_out));
  cover property ($rose(freq_hold_out));
  cover property ($fell(motor_output_phases_out));
endmodule
bind dfp_supervisor dfp_sup_asserts #(.MS_CYCLES(MS_CYCLES)) dfp_sup_asserts_inst (
  .mclk_in(mclk_in), .reset_in(reset_in), .ce_in(ce_in), .psel_in(psel_in),
  .penable_in(penable_in), .ext_fault_in(ext_fault_in), .accel_in(accel_in),
  .decel_in(decel_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .freq_hold_out(freq_hold_out), .fault_out(fault_out),
  .trip_out(trip_out), .motor_output_phases_out(motor_output_phases_out));
`default_nettype wire

/* tb/dfp_motor_model.sv */
/*
  Motor and power stage stand-in: load and regeneration settings become
  current and bus voltage samples one clock later.
  Assumes the bench clock; a ground short is raised on request.
*/
`default_nettype none
module dfp_motor_model (
  input  wire logic        mclk_in,
  input  wire logic [15:0] load_in,
  input  wire logic [15:0] regen_in,
  input  wire logic        gnd_short_in,
  output logic      [15:0] current_out,
  output logic      [15:0] bus_voltage_out,
  output logic             ground_fault_out
);
  always_ff @(posedge mclk_in) begin
    current_out <= load_in;
    bus_voltage_out <= regen_in;
  end
  assign ground_fault_out = gnd_short_in;
endmodule
`default_nettype wire

/* tb/tb_top.sv */
/*
  Self-checking bench of the supervisor beside a motor stand-in.
  Assumes MS_CYCLES of 1, so one millisecond is one clock.
*/
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic        ext = 1'b0;
  logic        acc = 1'b0;
  logic        dec = 1'b0;
  logic        gnd_short = 1'b0;
  logic        rdy, err, e, hold, warn, flt, trip, mop, irq, gnd;
  logic [6:0]  code = 7'h00;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [15:0] load = 16'h0, regen = 16'h0, cur, vbus;
  logic [15:0] base [5] = '{16'h0122, 16'h0122, 16'h0212, 16'h026c, 16'h0370};
  int          err_count = 0;
  int          num_checks = 0;
  always #4 mclk = ~mclk;
  dfp_motor_model dfp_motor_model_inst (.mclk_in(mclk), .load_in(load), .regen_in(regen),
    .gnd_short_in(gnd_short), .current_out(cur), .bus_voltage_out(vbus),
    .ground_fault_out(gnd));
  dfp_supervisor #(.MS_CYCLES(1)) dfp_supervisor_inst (
    .mclk_in(mclk), .reset_in(rst), .ce_in(1'b1), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'hf),
    .prdata_out(prdata), .pready_out(rdy), .pslverr_out(err), .current_in(cur),
    .bus_voltage_in(vbus), .accel_in(acc), .decel_in(dec), .ground_fault_in(gnd),
    .ext_fault_in(ext), .ext_fault_code_in(code), .freq_hold_out(hold),
    .overload_warn_out(warn), .fault_out(flt), .trip_out(trip),
    .motor_output_phases_out(mop), .irq_out(irq));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task stop_test;
    if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task chk_bit(input logic g, input logic x);
    chk({31'h0, g}, {31'h0, x});
  endtask
  task cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    pen <= 1'b1;
    do @(posedge mclk); while (rdy !== 1'b1);
    r = prdata;
    e = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x);
    xfer(1'b0, a, 32'h0);
    chk(r, x);
  endtask
  task pulse(input logic [6:0] c);
    @(posedge mclk);
    ext <= 1'b1;
    code <= c;
    @(posedge mclk);
    ext <= 1'b0;
    @(posedge mclk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_defaults;
    cyc(3);
    chk_bit(mop, 1'b1);
    rd(12'h000, 32'h3);
    rd(12'h004, 32'h0050_0064);
    rd(12'h008, 32'h9614_8200);
    rd(12'h00c, 32'h000a_0000);
    rd(12'h018, 32'h0);
    rd(12'h024, 32'h0);
    chk_bit(e, 1'b1);
    chk_bit(mop, 1'b0);
  endtask
  task t_ov_stall;
    wr(12'h008, 32'h9614_8204);
    dec <= 1'b1;
    for (int c = 0; c < 5; c++) begin
      wr(12'h010, {13'h0, 3'(c), 16'h0064});
      regen <= base[c] * 16'h000d / 16'h000a;
      cyc(4);
      chk_bit(hold, 1'b0);
      regen <= regen + 16'h0001;
      cyc(4);
      chk_bit(hold, 1'b1);
      regen <= 16'h0000;
      cyc(4);
      chk_bit(hold, 1'b0);
    end
    wr(12'h008, 32'h9614_8200);
    regen <= 16'h07d0;
    cyc(4);
    chk_bit(hold, 1'b0);
    regen <= 16'h0000;
    dec <= 1'b0;
  endtask
  task t_oc_stall;
    acc <= 1'b1;
    load <= 16'h0096;
    cyc(4);
    chk_bit(hold, 1'b0);
    load <= 16'h0097;
    cyc(4);
    chk_bit(hold, 1'b1);
    wr(12'h008, 32'h9600_8200);
    cyc(2);
    chk_bit(hold, 1'b0);
    load <= 16'h0000;
    acc <= 1'b0;
  endtask
  task t_faults;
    wr(12'h020, 32'h1);
    wr(12'h00c, 32'h0001_0001);
    wr(12'h000, 32'h7);
    pulse(7'h21);
    chk_bit(trip, 1'b1);
    chk_bit(flt, 1'b1);
    chk_bit(irq, 1'b1);
    rd(12'h014, 32'h0000_2105);
    cyc(80);
    chk_bit(trip, 1'b1);
    cyc(30);
    chk_bit(trip, 1'b0);
    rd(12'h014, 32'h0001_0000);
    wr(12'h01c, 32'h1f);
    cyc(1);
    chk_bit(irq, 1'b0);
    pulse(7'h21);
    rd(12'h014, 32'h0001_2106);
    cyc(150);
    chk_bit(trip, 1'b1);
    rd(12'h018, 32'h0000_2121);
    wr(12'h000, 32'hf);
    cyc(2);
    chk_bit(trip, 1'b0);
    rd(12'h014, 32'h0);
    wr(12'h000, 32'h3);
    pulse(7'h21);
    chk_bit(flt, 1'b0);
    cyc(120);
    chk_bit(trip, 1'b0);
  endtask
  task t_overload;
    wr(12'h000, 32'h2);
    wr(12'h004, 32'h0032_0032);
    load <= 16'h006e;
    cyc(2000);
    chk_bit(warn, 1'b0);
    wr(12'h000, 32'h3);
    cyc(29500);
    chk_bit(warn, 1'b0);
    cyc(1000);
    chk_bit(warn, 1'b1);
    cyc(29000);
    chk_bit(trip, 1'b0);
    cyc(1000);
    chk_bit(trip, 1'b1);
    rd(12'h018, 32'h0021_210b);
  endtask
  task t_ground;
    gnd_short <= 1'b1;
    rst <= 1'b1;
    cyc(2);
    chk_bit(trip, 1'b0);
    rst <= 1'b0;
    cyc(4);
    chk_bit(trip, 1'b1);
    chk_bit(mop, 1'b0);
    gnd_short <= 1'b0;
  endtask
  initial begin
    cyc(16);
    rst <= 1'b0;
    t_defaults();
    t_ov_stall();
    t_oc_stall();
    t_faults();
    t_overload();
    t_ground();
    stop_test();
  end
  initial begin
    cyc(80000);
    err_count++;
    stop_test();
  end
endmodule
`default_nettype wire
